//--- rtl/sfpe_flash.sv
`timescale 1ns/1ps
module sfpe_flash #(
  parameter int BYTE_PROGRAM_CYC = sfpe_pkg::BYTE_PROGRAM_CYC,
  parameter int PAGE_ERASE_CYC = sfpe_pkg::PAGE_ERASE_CYC,
  parameter int BLOCK_ERASE_CYC = sfpe_pkg::BLOCK_ERASE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // link
  sfpe_if.flash link,
  // array side
  input wire logic [15:0] sector_protect_i,
  input wire logic op_fail_i,
  output logic prog_o,
  output logic [23:0] prog_addr_o,
  output logic [7:0] prog_data_o,
  output logic erase_o,
  output logic [23:0] erase_addr_o,
  output logic [1:0] erase_kind_o,
  output logic busy_o,
  output logic write_enable_latch_o,
  output logic erase_program_error_flag_o,
  output logic seq_mode_o
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sck_s, cs_s, mosi_s;
  logic sck_d;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sck_s <= 2'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      sck_d <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], link.sck};
      cs_s <= {cs_s[0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
      sck_d <= sck_s[1];
    end
  end
  logic cs_n_q, cs_n_d;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) cs_n_d <= 1'b1;
    else cs_n_d <= cs_s[1];
  end
  assign cs_n_q = cs_s[1];
  wire sck_rise = cs_n_q == 1'b0 && sck_s[1] && !sck_d;
  wire sck_fall = cs_n_q == 1'b0 && !sck_s[1] && sck_d;
  wire frame_start = !cs_n_q && cs_n_d;
  wire frame_end = cs_n_q && !cs_n_d;
  // ****************************************
  // shifter
  // ****************************************
  logic [2:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic [7:0] shreg, opcode;
  logic [23:0] addr;
  logic [7:0] data;
  logic have_data;
  wire [7:0] next_byte = {shreg[6:0], mosi_s[1]};
  always_ff @(posedge clk_i) begin
    if (!nrst_i || frame_start) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      shreg <= 8'h00;
      have_data <= 1'b0;
    end else if (sck_rise) begin
      shreg <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (byte_cnt != 4'hF) byte_cnt <= byte_cnt + 4'h1;
        if (byte_cnt == 4'h0) opcode <= next_byte;
        else if (byte_cnt <= 4'h3) addr <= {addr[15:0], next_byte};
        if (byte_cnt >= 4'h1) begin
          data <= next_byte;
          have_data <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // command decode at frame end
  // ****************************************
  wire aligned = bit_cnt == 3'h0;
  wire is_seq = opcode == sfpe_pkg::OP_SEQ_A || opcode == sfpe_pkg::OP_SEQ_B;
  wire is_blk = opcode == sfpe_pkg::OP_ERASE_4K || opcode == sfpe_pkg::OP_ERASE_32K
    || opcode == sfpe_pkg::OP_ERASE_64K;
  wire is_page = opcode == sfpe_pkg::OP_PAGE_ERASE;
  logic [23:0] blk_base;
  logic blk_prot;
  always_comb begin
    blk_base = addr;
    blk_prot = sector_protect_i[addr[19:16]];
    case (opcode)
      sfpe_pkg::OP_ERASE_4K: blk_base = {addr[23:12], 12'h000};
      sfpe_pkg::OP_ERASE_32K: blk_base = {addr[23:15], 15'h0000};
      default: blk_base = {addr[23:16], 16'h0000};
    endcase
  end
  wire [23:0] page_base = {13'h0000, addr[18:16], addr[15:8]} << 8;
  logic [23:0] seq_addr;
  wire [23:0] seq_next = seq_addr + 24'h00_0001;
  // byte about to be programmed and whether it is the last the mode may take
  wire [23:0] prog_at = seq ? seq_next : addr;
  wire [23:0] prog_after = prog_at + 24'h00_0001;
  wire seq_last = prog_at == sfpe_pkg::TOP_ADDR || sector_protect_i[prog_after[19:16]];
  logic write_enable_latch, seq, seq_stop, busy, erase_program_error_flag, irq_wait;
  logic [31:0] timer;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      write_enable_latch <= 1'b0;
      seq <= 1'b0;
      seq_stop <= 1'b0;
      seq_addr <= 24'h00_0000;
      prog_o <= 1'b0;
      erase_o <= 1'b0;
      prog_addr_o <= 24'h00_0000;
      prog_data_o <= 8'h00;
      erase_addr_o <= 24'h00_0000;
      erase_kind_o <= 2'h0;
      busy <= 1'b0;
      timer <= 32'h0000_0000;
      erase_program_error_flag <= 1'b0;
    end else begin
      prog_o <= 1'b0;
      erase_o <= 1'b0;
      if (busy) begin
        if (op_fail_i) erase_program_error_flag <= 1'b1;
        if (timer == 32'h0000_0001) begin
          busy <= 1'b0;
          // mode and latch drop together once the last byte is in
          if (seq_stop) seq <= 1'b0;
          write_enable_latch <= seq && !seq_stop;
        end
        timer <= timer - 32'h0000_0001;
      end else if (frame_end && byte_cnt != 4'h0) begin
        if (!aligned) begin
          if (opcode != sfpe_pkg::OP_WRITE_EN && opcode != sfpe_pkg::OP_WRITE_DIS) begin
            write_enable_latch <= 1'b0;
            seq <= 1'b0;
          end
        end else if (opcode == sfpe_pkg::OP_WRITE_EN) begin
          write_enable_latch <= 1'b1;
        end else if (opcode == sfpe_pkg::OP_WRITE_DIS) begin
          write_enable_latch <= 1'b0;
          seq <= 1'b0;
        end else if (is_seq && write_enable_latch) begin
          if (!seq) begin
            if (byte_cnt < 4'h5 || sector_protect_i[addr[19:16]]) begin
              write_enable_latch <= 1'b0;
            end else begin
              prog_o <= 1'b1;
              prog_addr_o <= addr;
              prog_data_o <= data;
              seq_addr <= addr;
              seq <= 1'b1;
              seq_stop <= seq_last;
              busy <= 1'b1;
              timer <= BYTE_PROGRAM_CYC;
              erase_program_error_flag <= 1'b0;
            end
          end else if (!have_data) begin
            write_enable_latch <= 1'b0;
            seq <= 1'b0;
          end else if (seq_addr == sfpe_pkg::TOP_ADDR
              || sector_protect_i[seq_next[19:16]]) begin
            write_enable_latch <= 1'b0;
            seq <= 1'b0;
          end else begin
            prog_o <= 1'b1;
            prog_addr_o <= seq_next;
            prog_data_o <= data;
            seq_addr <= seq_next;
            busy <= 1'b1;
            timer <= BYTE_PROGRAM_CYC;
            erase_program_error_flag <= 1'b0;
            // last byte of array, or last byte before a protected sector, ends the mode after programming
            seq_stop <= seq_last;
          end
        end else if ((is_blk || is_page) && write_enable_latch) begin
          if (byte_cnt < 4'h4 || (is_blk && blk_prot) || (is_page && sector_protect_i[page_base[19:16]])) begin
            write_enable_latch <= 1'b0;
          end else begin
            erase_o <= 1'b1;
            erase_addr_o <= is_page ? page_base : blk_base;
            erase_kind_o <= is_page ? 2'h0 : (opcode == sfpe_pkg::OP_ERASE_4K ? 2'h1
              : opcode == sfpe_pkg::OP_ERASE_32K ? 2'h2 : 2'h3);
            busy <= 1'b1;
            timer <= is_page ? PAGE_ERASE_CYC : BLOCK_ERASE_CYC;
            // an erase also ends any sequential run
            seq_stop <= 1'b1;
            erase_program_error_flag <= 1'b0;
          end
        end
      end
    end
  end
  // ****************************************
  // status readout and active status interrupt
  // ****************************************
  logic [7:0] status, out_sh;
  logic [4:0] clk_cnt;
  logic miso, miso_oe;
  assign status = {2'h0, erase_program_error_flag, 3'h0, write_enable_latch, busy};
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      clk_cnt <= 5'h00;
      irq_wait <= 1'b0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
      out_sh <= 8'h00;
    end else if (cs_n_q) begin
      clk_cnt <= 5'h00;
      irq_wait <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      if (sck_rise && clk_cnt != 5'h1F) clk_cnt <= clk_cnt + 5'h01;
      if (sck_fall && byte_cnt != 4'h0 && (opcode == sfpe_pkg::OP_READ_STATUS
          || opcode == sfpe_pkg::OP_STATUS_IRQ) && !irq_wait) begin
        miso_oe <= 1'b1;
        miso <= (bit_cnt == 3'h0) ? status[7] : out_sh[7];
        out_sh <= (bit_cnt == 3'h0) ? {status[6:0], 1'b0} : {out_sh[6:0], 1'b0};
      end
      if (opcode == sfpe_pkg::OP_STATUS_IRQ && clk_cnt == 5'(sfpe_pkg::IRQ_CLOCKS)) begin
        irq_wait <= 1'b1;
        miso_oe <= 1'b1;
        miso <= busy;
      end
    end
  end
  assign link.miso = miso;
  assign link.miso_oe = miso_oe;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      write_enable_latch_o <= 1'b0;
      erase_program_error_flag_o <= 1'b0;
      seq_mode_o <= 1'b0;
    end else begin
      busy_o <= busy;
      write_enable_latch_o <= write_enable_latch;
      erase_program_error_flag_o <= erase_program_error_flag;
      seq_mode_o <= seq;
    end
  end
endmodule

//--- pkg/sfpe_pkg.sv
// Overview of operation
// - host sets write enable before sequential mode
// - first sequential frame: opcode, address, data
// - frame end starts timed byte program
// - later frames: opcode and data, next address
// - host ends sequential mode with write disable
// - only last complete data byte is kept
// - short or ragged frame aborts, clears latch
// - protected start address: no program, clear latch
// - top array byte ends mode, clears latch
// - protected next sector ends mode, clears latch
// - busy shows while a byte programs
// - failed program or erase sets error flag
// - page erase 81h, page address in bytes
// - page erase at frame end, busy meanwhile
// - block erase opcode selects erase size
// - host sets write enable before block erase
// - block erase: opcode, address, extras ignored
// - block erase ignores low address bits
// - short or ragged erase frame aborts, clears latch
// - protected block skips erase, clears latch
// - busy during erase, latch cleared as busy ends
// - status interrupt: output low when busy ends
package sfpe_pkg;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_SEQ_A = 8'hAD;
  localparam logic [7:0] OP_SEQ_B = 8'hAF;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_STATUS_IRQ = 8'h25;
  // ****************************************
  // array geometry
  // ****************************************
  localparam logic [23:0] TOP_ADDR = 24'h07_FFFF;
  localparam int SECTOR_SHIFT = 16;
  localparam int IRQ_CLOCKS = 16;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_EPE = 5;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 25;
  localparam int BYTE_PROGRAM_TIME_NS = 8000;
  localparam int PAGE_ERASE_TIME_NS = 8000;
  localparam int BLOCK_ERASE_TIME_NS = 16000;
  localparam int BYTE_PROGRAM_CYC = (BYTE_PROGRAM_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_ERASE_CYC = (PAGE_ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLOCK_ERASE_CYC = (BLOCK_ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF_CYC = 4;
endpackage

//--- pkg/sfpe_if.sv
`timescale 1ns/1ps
interface sfpe_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport flash (input sck, input cs_n, input mosi, output miso, output miso_oe);
  modport host (output sck, output cs_n, output mosi, input miso, input miso_oe);
endinterface

//--- rtl/sfpe_host.sv
`timescale 1ns/1ps
module sfpe_host #(
  parameter int MAX_BYTES = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // link
  sfpe_if.host link,
  // user request
  input wire logic req_i,
  input wire logic [3:0] nbytes_i,
  input wire logic [63:0] tx_i,
  output logic ready_o,
  output logic done_o,
  output logic [7:0] rx_o
);
  // ****************************************
  // frame engine; the bench sends write enable before sequential and erase, except one sequential frame after write disable
  // ****************************************
  logic [1:0] miso_s;
  logic [63:0] sh;
  logic [6:0] bits_left;
  logic [2:0] div;
  logic sck, cs_n, mosi, busy;
  logic [7:0] rx;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) miso_s <= 2'h0;
    else miso_s <= {miso_s[0], link.miso};
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sck <= 1'b0;
      cs_n <= 1'b1;
      mosi <= 1'b0;
      busy <= 1'b0;
      sh <= 64'h0000_0000_0000_0000;
      bits_left <= 7'h00;
      div <= 3'h0;
      rx <= 8'h00;
      ready_o <= 1'b0;
      done_o <= 1'b0;
      rx_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      ready_o <= !busy && !req_i;
      if (!busy) begin
        if (req_i && nbytes_i != 4'h0) begin
          busy <= 1'b1;
          ready_o <= 1'b0;
          cs_n <= 1'b0;
          sh <= tx_i;
          mosi <= tx_i[63];
          bits_left <= {nbytes_i[3:0], 3'h0};
          div <= 3'h0;
        end
      end else if (bits_left == 7'h00) begin
        if (div == 3'(sfpe_pkg::SCK_HALF_CYC)) begin
          cs_n <= 1'b1;
          busy <= 1'b0;
          done_o <= 1'b1;
          rx_o <= rx;
        end
        div <= div + 3'h1;
      end else if (div == 3'(sfpe_pkg::SCK_HALF_CYC - 1)) begin
        div <= 3'h0;
        sck <= !sck;
        // sample just before the fall: pin sync on both ends outlasts half a period
        if (sck) begin
          rx <= {rx[6:0], miso_s[1]};
          sh <= {sh[62:0], 1'b0};
          mosi <= sh[62];
          bits_left <= bits_left - 7'h01;
        end
      end else begin
        div <= div + 3'h1;
      end
    end
  end
  assign link.sck = sck;
  assign link.cs_n = cs_n;
  assign link.mosi = mosi;
endmodule

//--- verif/sfpe_chk.sv
`timescale 1ns/1ps
module sfpe_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic miso_oe,
  // flash status
  input wire logic prog_o,
  input wire logic erase_o,
  input wire logic busy_o,
  input wire logic write_enable_latch_o,
  input wire logic seq_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ****
  // link and command rules
  // ****
  a_sck_idle_still: assert property (cs_n && $past(cs_n) |-> $stable(sck))
    else $error("serial clock moved outside a frame");
  a_prog_after_frame: assert property (prog_o |-> cs_n ##1 busy_o)
    else $error("program start not after frame end or no busy");
  a_prog_one_pulse: assert property (prog_o |=> !prog_o)
    else $error("program start longer than one cycle");
  a_seq_needs_latch: assert property ($rose(seq_mode_o) |-> write_enable_latch_o)
    else $error("sequential mode entered without latch");
  a_erase_needs_latch: assert property (erase_o |-> write_enable_latch_o)
    else $error("erase started without latch");
  a_erase_busy_holds: assert property (erase_o |=> busy_o [*8])
    else $error("busy not held after erase start");
  a_no_start_busy: assert property (busy_o |-> !prog_o && !erase_o)
    else $error("operation started while busy");
  a_seq_exit_clear: assert property ($fell(seq_mode_o) |-> ##[0:2] !write_enable_latch_o)
    else $error("latch kept after sequential exit");
  a_busy_end_clear: assert property ($fell(busy_o) && !seq_mode_o |-> ##[0:2] !write_enable_latch_o)
    else $error("latch kept after operation end");
  // sync delay: flash sees the frame end a few cycles late
  a_miso_released: assert property (cs_n [*4] |-> !miso_oe)
    else $error("serial output driven while deselected");
endmodule

//--- verif/tb_serial_flash_seq_program_erase.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_serial_flash_seq_program_erase;
  // short timed cycles keep the run brief
  localparam int BPC = 200;
  localparam int PEC = 300;
  localparam int BEC = 400;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req = 1'b0;
  logic [3:0] nbytes = 4'h0;
  logic [63:0] tx = 64'h0;
  logic [15:0] prot = 16'h0000;
  logic fail = 1'b0;
  logic ready, done, prog, erase, busy, write_enable_latch, err, seqm, wel2, erase2;
  logic [7:0] pd, pd_o, sh, rx;
  logic [23:0] pa, pa_o, ea, ea_o;
  logic [1:0] ek, ek_o;
  logic [7:0] ops [3] = '{sfpe_pkg::OP_ERASE_4K, sfpe_pkg::OP_ERASE_32K, sfpe_pkg::OP_ERASE_64K};
  logic [23:0] msk [3] = '{24'hFF_F000, 24'hFF_8000, 24'hFF_0000};
  int n_fail = 0, check_count = 0, np = 0, ne = 0, ne2 = 0, bcnt = 0, nb = 0;
  sfpe_if lk();
  sfpe_if lk2();
  always #12.5 clk = ~clk;
  sfpe_flash #(.BYTE_PROGRAM_CYC(BPC), .PAGE_ERASE_CYC(PEC), .BLOCK_ERASE_CYC(BEC)) sfpe_flash_i (
    .clk_i(clk), .nrst_i(nrst), .link(lk.flash), .sector_protect_i(prot), .op_fail_i(fail),
    .prog_o(prog), .prog_addr_o(pa_o), .prog_data_o(pd_o), .erase_o(erase), .erase_addr_o(ea_o),
    .erase_kind_o(ek_o), .busy_o(busy), .write_enable_latch_o(write_enable_latch), .erase_program_error_flag_o(err),
    .seq_mode_o(seqm));
  sfpe_host sfpe_host_i (.clk_i(clk), .nrst_i(nrst), .link(lk.host), .req_i(req), .nbytes_i(nbytes),
    .tx_i(tx), .ready_o(ready), .done_o(done), .rx_o(rx));
  // second flash faces a bit-level driver that breaks framing
  sfpe_flash #(.BYTE_PROGRAM_CYC(BPC), .PAGE_ERASE_CYC(PEC), .BLOCK_ERASE_CYC(BEC)) sfpe_flash_b_i (
    .clk_i(clk), .nrst_i(nrst), .link(lk2.flash), .sector_protect_i(16'h0000), .op_fail_i(1'b0),
    .prog_o(), .prog_addr_o(), .prog_data_o(), .erase_o(erase2), .erase_addr_o(), .erase_kind_o(),
    .busy_o(), .write_enable_latch_o(wel2), .erase_program_error_flag_o(), .seq_mode_o());
  sfpe_chk sfpe_chk_i (.clk_i(clk), .nrst_i(nrst), .sck(lk.sck), .cs_n(lk.cs_n), .miso_oe(lk.miso_oe),
    .prog_o(prog), .erase_o(erase), .busy_o(busy), .write_enable_latch_o(write_enable_latch), .seq_mode_o(seqm));
  // ****
  // monitors
  // ****
  always @(posedge clk) begin
    if (prog) begin np++; pa = pa_o; pd = pd_o; end
    if (erase) begin ne++; ea = ea_o; ek = ek_o; end
    if (erase2) ne2++;
    if (busy) bcnt++;
  end
  always @(negedge lk.cs_n) nb = 0;
  always @(posedge lk.sck) if (!lk.cs_n) begin sh = {sh[6:0], lk.mosi}; nb++; end
  // ****
  // tasks
  // ****
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hang(input int k, input int lim);
    if (k >= lim) begin n_fail++; end_of_test(); end
  endtask
  task automatic send(input int n, input logic [63:0] d);
    int k;
    bcnt = 0;
    req = 1'b1;
    nbytes = n[3:0];
    tx = d << (64 - 8 * n);
    k = 0;
    do begin @(negedge clk); k++; end while (ready !== 1'b0 && k < 100);
    hang(k, 100);
    req = 1'b0;
    k = 0;
    do begin @(posedge clk); k++; end while (done !== 1'b1 && k < 3000);
    hang(k, 3000);
    `CHK(nb, 8 * n)
    `CHK(sh, d[7:0])
  endtask
  task automatic xfer(input int n, input logic [63:0] d);
    int k;
    send(n, d);
    repeat (8) @(negedge clk);
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin @(negedge clk); k++; end
    hang(k, 3000);
  endtask
  task automatic we();
    xfer(1, sfpe_pkg::OP_WRITE_EN);
  endtask
  task automatic bb(input int nbits, input logic [39:0] d, input bit keep);
    lk2.cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      lk2.mosi = d[39 - i];
      repeat (4) @(negedge clk);
      lk2.sck = 1'b1;
      repeat (4) @(negedge clk);
      lk2.sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    // keep leaves the frame open for the status interrupt
    lk2.cs_n = !keep;
    lk2.mosi = ~lk2.mosi;
    repeat (12) @(negedge clk);
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    lk2.sck = 1'b0;
    lk2.cs_n = 1'b1;
    lk2.mosi = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    we();
    `CHK(write_enable_latch, 1'b1)
    xfer(5, {sfpe_pkg::OP_SEQ_A, 32'h0100_005A});
    `CHK(np, 1)
    `CHK(pa, 24'h01_0000)
    `CHK(pd, 8'h5A)
    `CHK(bcnt, BPC)
    send(3, {sfpe_pkg::OP_SEQ_B, 16'h1122});
    repeat (8) @(negedge clk);
    // status read lands while the byte programs
    xfer(2, {sfpe_pkg::OP_READ_STATUS, 8'h00});
    `CHK(rx, 8'h03)
    `CHK(pa, 24'h01_0001)
    `CHK(pd, 8'h22)
    `CHK(write_enable_latch, 1'b1)
    xfer(1, sfpe_pkg::OP_WRITE_DIS);
    `CHK(seqm, 1'b0)
    xfer(5, {sfpe_pkg::OP_SEQ_A, 32'h0200_0033});
    `CHK(np, 2)
    prot = 16'h0002;
    we();
    xfer(5, {sfpe_pkg::OP_SEQ_A, 32'h0100_0044});
    `CHK(np, 2)
    `CHK(write_enable_latch, 1'b0)
    we();
    xfer(5, {sfpe_pkg::OP_SEQ_A, 32'h00FF_FF55});
    `CHK(pa, 24'h00_FFFF)
    `CHK(seqm, 1'b0)
    `CHK(write_enable_latch, 1'b0)
    prot = 16'h0000;
    we();
    xfer(5, {sfpe_pkg::OP_SEQ_A, 32'h07FF_FF66});
    `CHK(pa, sfpe_pkg::TOP_ADDR)
    `CHK(seqm, 1'b0)
    `CHK(write_enable_latch, 1'b0)
    we();
    xfer(4, {sfpe_pkg::OP_SEQ_A, 24'h01_0000});
    `CHK(np, 4)
    `CHK(write_enable_latch, 1'b0)
    we();
    xfer(4, {sfpe_pkg::OP_PAGE_ERASE, 24'hFD_A377});
    `CHK(ek, 2'd0)
    `CHK(ea[18:8], 11'h5A3)
    `CHK(bcnt, PEC)
    `CHK(write_enable_latch, 1'b0)
    for (int i = 0; i < 3; i++) begin
      fail = (i == 1);
      we();
      xfer(6, {ops[i], 24'h03_ABCD, 16'hEEFF});
      fail = 1'b0;
      `CHK(ne, 2 + i)
      `CHK(ek, 2'(i + 1))
      `CHK(ea & msk[i], 24'h03_ABCD & msk[i])
      `CHK(bcnt, BEC)
      `CHK(err, (i == 1))
    end
    prot = 16'h0008;
    we();
    xfer(4, {sfpe_pkg::OP_ERASE_64K, 24'h03_0000});
    `CHK(ne, 4)
    `CHK(write_enable_latch, 1'b0)
    prot = 16'h0000;
    we();
    xfer(3, {sfpe_pkg::OP_ERASE_4K, 16'h0100});
    `CHK(ne, 4)
    `CHK(write_enable_latch, 1'b0)
    bb(8, {sfpe_pkg::OP_WRITE_EN, 32'h0000_0000}, 1'b0);
    `CHK(wel2, 1'b1)
    bb(36, {sfpe_pkg::OP_ERASE_4K, 32'h0100_00F0}, 1'b0);
    `CHK(wel2, 1'b0)
    `CHK(ne2, 0)
    bb(8, {sfpe_pkg::OP_WRITE_EN, 32'h0000_0000}, 1'b0);
    bb(32, {sfpe_pkg::OP_ERASE_4K, 32'h0100_0000}, 1'b0);
    `CHK(ne2, 1)
    bb(16, {sfpe_pkg::OP_STATUS_IRQ, 32'h0000_0000}, 1'b1);
    `CHK(lk2.miso_oe, 1'b1)
    `CHK(lk2.miso, 1'b1)
    repeat (BEC) @(negedge clk);
    `CHK(lk2.miso, 1'b0)
    lk2.cs_n = 1'b1;
    repeat (4) @(negedge clk);
    end_of_test();
  end
endmodule
